// ---- common/ppc_pkg.sv ----
// Shared constants and types for the port power and overcurrent controller
`default_nettype none
package ppc_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned NUM_PORTS = 6;
  // Index of the extra channel that watches the shared pin
  localparam int unsigned GANG_CH = 6;
  localparam int unsigned NUM_CH = 7;

  // ==========================================================
  // Timebase: 1 ms derived from the 200 MHz core clock
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 18;

  // ==========================================================
  // Register offsets on the internal configuration port
  localparam logic [15:0] OFS_MIN_PULSE_WIDTH = 16'h30ea;
  localparam logic [15:0] OFS_DOUBLE_WINDOW = 16'h30eb;
  localparam logic [15:0] OFS_START_LOCKOUT = 16'h30e1;

  // ==========================================================
  // Field layout and reset values
  localparam int unsigned MIN_WIDTH_MSB = 3;
  localparam int unsigned MIN_WIDTH_W = 4;
  localparam logic [3:0] MIN_WIDTH_RST = 4'h5;
  localparam logic [7:0] DOUBLE_WINDOW_RST = 8'h14;
  localparam logic [7:0] START_LOCKOUT_RST = 8'h0a;

  // Timing configuration carried to every channel
  typedef struct packed {
    logic [3:0] min_width;
    logic [7:0] double_window;
    logic [7:0] start_lockout;
  } ppc_cfg_s;

  // Per-channel pin drive bundle
  typedef struct packed {
    logic drive_o;
    logic drive_oe;
    logic pullup_en;
  } ppc_pin_s;

endpackage

`default_nettype wire

// ---- core/ppc_port_power.sv ----
// Per-port power control and overcurrent detection for downstream hub ports
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Individual mode default: one pin per port
// - Ganged mode: shared pin powers all ports
// - Ganged overcurrent flags every downstream port
// - Mode comes only from loaded configuration
// - Power off: drive low, pull-up off
// - Power on: release driver, pull-up on
// - Enabled port pin sampled continuously
// - Continuous low for min width reports
// - Two low runs inside window report
// - Ignore pin during start lockout time
// - Min width 4 bits, default 5 ms
// - Filter tolerates short transient lows
// - Chip reset restores all register defaults
// - Double window 8 bits, default 20 ms
// - Start lockout 8 bits, default 10 ms
module ppc_port_power #(
  parameter int unsigned TICK_CYCLES = ppc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Configuration strap from loaded settings
  input wire logic gang_mode_i,
  // Power requests from hub status logic, one per port
  input wire logic [5:0] port_power_on_i,
  // Internal configuration register port
  input wire logic [15:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // Per-port combined power and sense pins
  input wire logic [5:0] port_power_sense_pin_i,
  output logic [5:0] port_power_sense_pin_o,
  output logic [5:0] port_power_sense_pin_oe_o,
  output logic [5:0] port_power_sense_pullup_o,
  // Shared pin used in ganged mode
  input wire logic shared_power_sense_pin_i,
  output logic shared_power_sense_pin_o,
  output logic shared_power_sense_pin_oe_o,
  output logic shared_power_sense_pullup_o,
  // Sticky overcurrent flags, one per port
  output logic [5:0] oc_flag_o
);

  // ==========================================================
  // Declarations
  ppc_pkg::ppc_cfg_s cfg_q;       // Timing configuration
  logic [ppc_pkg::TICK_CNT_W-1:0] tick_cnt_q;
  logic tick_q;                   // One-cycle 1 ms strobe
  logic [ppc_pkg::NUM_CH-1:0] ch_en;    // Channel power enable
  logic [ppc_pkg::NUM_CH-1:0] ch_pin;   // Raw pin level per channel
  logic [ppc_pkg::NUM_CH-1:0] ch_flag;  // Sticky flag per channel
  ppc_pkg::ppc_pin_s pin_drv [ppc_pkg::NUM_CH];

  // ==========================================================
  // Configuration registers
  // defaults on reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_q.min_width <= ppc_pkg::MIN_WIDTH_RST;
      cfg_q.double_window <= ppc_pkg::DOUBLE_WINDOW_RST;
      cfg_q.start_lockout <= ppc_pkg::START_LOCKOUT_RST;
    end else if (cfg_wr_i) begin
      case (cfg_addr_i)
        // Upper nibble is reserved and not stored
        ppc_pkg::OFS_MIN_PULSE_WIDTH: begin
          cfg_q.min_width <= cfg_wdata_i[ppc_pkg::MIN_WIDTH_MSB:0];
        end
        ppc_pkg::OFS_DOUBLE_WINDOW: begin
          cfg_q.double_window <= cfg_wdata_i;
        end
        ppc_pkg::OFS_START_LOCKOUT: begin
          cfg_q.start_lockout <= cfg_wdata_i;
        end
        // Writes elsewhere are dropped
        default: begin
        end
      endcase
    end
  end

  // Read data, registered; unmapped and reserved bits read zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 8'h00;
    end else begin
      case (cfg_addr_i)
        ppc_pkg::OFS_MIN_PULSE_WIDTH: begin
          cfg_rdata_o <= {{(8 - ppc_pkg::MIN_WIDTH_W){1'b0}}, cfg_q.min_width};
        end
        ppc_pkg::OFS_DOUBLE_WINDOW: begin
          cfg_rdata_o <= cfg_q.double_window;
        end
        ppc_pkg::OFS_START_LOCKOUT: begin
          cfg_rdata_o <= cfg_q.start_lockout;
        end
        default: begin
          cfg_rdata_o <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // Millisecond timebase
  // tick from core clock
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == ppc_pkg::TICK_CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // Channel selection by mode
  // mode from strap only
  always_comb begin
    ch_en[ppc_pkg::NUM_PORTS-1:0] = gang_mode_i ? 6'h00 : port_power_on_i;
    ch_en[ppc_pkg::GANG_CH] = gang_mode_i & (|port_power_on_i);
    ch_pin = {shared_power_sense_pin_i, port_power_sense_pin_i};
  end

  // ==========================================================
  // One detector per channel; the last one watches the shared pin
  for (genvar ch = 0; ch < ppc_pkg::NUM_CH; ch++) begin : g_ch
    logic sync1_q;          // First synchroniser stage, read only by sync2
    logic sync2_q;          // Safe pin sample
    logic en_q;             // Enable seen last cycle
    logic locked_q;         // Start lockout running
    logic [7:0] lock_cnt_q;
    logic [3:0] run_cnt_q;  // Milliseconds of continuous low
    logic prev_low_q;       // Previous qualified sample was low
    logic armed_q;          // First low run ended, window open
    logic [7:0] win_cnt_q;
    logic flag_q;
    logic low;              // Qualified low sample
    logic single_hit;
    logic double_hit;

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        sync1_q <= 1'b1;
        sync2_q <= 1'b1;
      end else begin
        sync1_q <= ch_pin[ch];
        sync2_q <= sync1_q;
      end
    end

    // low on the line means overcurrent
    // sampled only while enabled and unlocked
    // The power-on cycle is masked too: the lockout flop is not yet set
    // and the synchroniser still shows the low that was driven while off
    assign low = ch_en[ch] & en_q & ~locked_q & ~sync2_q;
    assign single_hit = low & (run_cnt_q >= cfg_q.min_width);
    // new low run inside open window
    assign double_hit = low & ~prev_low_q & armed_q;

    // Start lockout after each power-on edge
    // ignore pin during lockout
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        en_q <= 1'b0;
        locked_q <= 1'b0;
        lock_cnt_q <= 8'h00;
      end else begin
        en_q <= ch_en[ch];
        if (ch_en[ch] & ~en_q) begin
          locked_q <= 1'b1;
          lock_cnt_q <= 8'h00;
        end else if (~ch_en[ch]) begin
          locked_q <= 1'b0;
        end else if (locked_q & tick_q) begin
          // A zero setting still gives one tick of lockout
          if (lock_cnt_q + 8'h01 >= cfg_q.start_lockout) begin
            locked_q <= 1'b0;
          end
          lock_cnt_q <= lock_cnt_q + 8'h01;
        end
      end
    end

    // Low-run width counter, saturating
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        run_cnt_q <= 4'h0;
        prev_low_q <= 1'b0;
      end else begin
        prev_low_q <= low;
        if (~low) begin
          run_cnt_q <= 4'h0;
        end else if (tick_q && run_cnt_q != 4'hf) begin
          run_cnt_q <= run_cnt_q + 4'h1;
        end
      end
    end

    // Rolling double-pulse window opened by the end of a low run
    // one short low only arms the window
    always_ff @(posedge mclk_i) begin
      if (rst_i || !ch_en[ch] || locked_q) begin
        armed_q <= 1'b0;
        win_cnt_q <= 8'h00;
      end else if (prev_low_q & ~low) begin
        armed_q <= 1'b1;
        win_cnt_q <= 8'h00;
      end else if (armed_q & tick_q) begin
        // Window expiry; the far side keeps the setting non-zero
        if (win_cnt_q + 8'h01 >= cfg_q.double_window) begin
          armed_q <= 1'b0;
        end
        win_cnt_q <= win_cnt_q + 8'h01;
      end
    end

    // sticky until power off; set wins
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        flag_q <= 1'b0;
      end else if (single_hit | double_hit) begin
        flag_q <= 1'b1;
      end else if (~ch_en[ch]) begin
        flag_q <= 1'b0;
      end
    end

    assign ch_flag[ch] = flag_q;

    always_comb begin
      pin_drv[ch].drive_o = 1'b0;
      pin_drv[ch].drive_oe = ~ch_en[ch];
      pin_drv[ch].pullup_en = ch_en[ch];
    end
  end

  // ==========================================================
  // Pin outputs
  for (genvar p = 0; p < ppc_pkg::NUM_PORTS; p++) begin : g_pin
    assign port_power_sense_pin_o[p] = pin_drv[p].drive_o;
    assign port_power_sense_pin_oe_o[p] = pin_drv[p].drive_oe;
    assign port_power_sense_pullup_o[p] = pin_drv[p].pullup_en;
  end
  assign shared_power_sense_pin_o = pin_drv[ppc_pkg::GANG_CH].drive_o;
  assign shared_power_sense_pin_oe_o = pin_drv[ppc_pkg::GANG_CH].drive_oe;
  assign shared_power_sense_pullup_o = pin_drv[ppc_pkg::GANG_CH].pullup_en;

  // ==========================================================
  // Flag outputs
  // shared overcurrent flags all ports
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      oc_flag_o <= 6'h00;
    end else if (gang_mode_i) begin
      oc_flag_o <= {ppc_pkg::NUM_PORTS{ch_flag[ppc_pkg::GANG_CH]}};
    end else begin
      oc_flag_o <= ch_flag[ppc_pkg::NUM_PORTS-1:0];
    end
  end

endmodule

`default_nettype wire

// ---- tb/ppc_switch_model.sv ----
// Behavioural power switch and pull-up network on every sense pin
`timescale 1ns/1ps
`default_nettype none
module ppc_switch_model (
  // Clock and pin controls from the block
  input wire logic clk_i,
  input wire logic [6:0] oe_i,
  input wire logic [6:0] drv_i,
  input wire logic [6:0] pull_i,
  // Overcurrent requests from the bench
  input wire logic [6:0] fault_i,
  // Resolved pin levels
  output logic [6:0] pin_o
);
  // Last level, inverted on a line that nobody holds
  logic [6:0] last_q;
  always_ff @(posedge clk_i) begin
    last_q <= pin_o;
  end
  always_comb begin
    for (int c = 0; c < 7; c++) begin
      pin_o[c] = oe_i[c] ? drv_i[c] : fault_i[c] ? 1'b0 : pull_i[c] ? 1'b1 : ~last_q[c];
    end
  end
endmodule
`default_nettype wire

// ---- tb/ppc_port_power_monitor.sv ----
// Assertion checker for the port power and overcurrent controller
`timescale 1ns/1ps
`default_nettype none
module ppc_port_power_monitor (
  // Clock, reset and requests
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic gang_mode_i,
  input wire logic [5:0] port_power_on_i,
  // Pin controls and flags
  input wire logic [5:0] port_power_sense_pin_o,
  input wire logic [5:0] port_power_sense_pin_oe_o,
  input wire logic [5:0] port_power_sense_pullup_o,
  input wire logic shared_power_sense_pin_o,
  input wire logic shared_power_sense_pin_oe_o,
  input wire logic shared_power_sense_pullup_o,
  input wire logic [5:0] oc_flag_o
);
  // ==========================================================
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_drive_low;
    port_power_sense_pin_o == 6'h00 && !shared_power_sense_pin_o;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("drive value not low");
  property p_indiv_oe;
    !gang_mode_i |-> port_power_sense_pin_oe_o == ~port_power_on_i;
  endproperty
  a_indiv_oe: assert property (p_indiv_oe) else $error("port enable wrong");
  property p_pullup;
    port_power_sense_pullup_o == ~port_power_sense_pin_oe_o
      && shared_power_sense_pullup_o != shared_power_sense_pin_oe_o;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not opposite drive");
  property p_gang_oe;
    gang_mode_i |-> port_power_sense_pin_oe_o == 6'h3f;
  endproperty
  a_gang_oe: assert property (p_gang_oe) else $error("port pin released in ganged mode");
  property p_shared_oe;
    shared_power_sense_pin_oe_o == !(gang_mode_i && |port_power_on_i);
  endproperty
  a_shared_oe: assert property (p_shared_oe) else $error("shared enable wrong");
  // Flags may only change together once ganged mode has settled
  property p_gang_flags;
    gang_mode_i [*4] |-> oc_flag_o inside {6'h00, 6'h3f};
  endproperty
  a_gang_flags: assert property (p_gang_flags) else $error("ganged flags differ");
  property p_clear;
    (port_power_on_i == 6'h00) [*3] |-> oc_flag_o == 6'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept after power off");
  property p_sticky;
    (|($past(oc_flag_o) & ~oc_flag_o & $past(port_power_on_i, 2))) == 1'b0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped while powered");
  c_indiv: cover property (!gang_mode_i && $rose(|oc_flag_o));
  c_gang: cover property (gang_mode_i && $rose(oc_flag_o == 6'h3f));
  c_clear: cover property ($fell(|oc_flag_o));
endmodule
bind ppc_port_power ppc_port_power_monitor mon_u (.mclk_i(mclk_i), .rst_i(rst_i),
  .gang_mode_i(gang_mode_i), .port_power_on_i(port_power_on_i),
  .port_power_sense_pin_o(port_power_sense_pin_o),
  .port_power_sense_pin_oe_o(port_power_sense_pin_oe_o),
  .port_power_sense_pullup_o(port_power_sense_pullup_o),
  .shared_power_sense_pin_o(shared_power_sense_pin_o),
  .shared_power_sense_pin_oe_o(shared_power_sense_pin_oe_o),
  .shared_power_sense_pullup_o(shared_power_sense_pullup_o), .oc_flag_o(oc_flag_o));
`default_nettype wire

// ---- tb/port_power_overcurrent_ctl_tb.sv ----
// Self-checking bench for the port power and overcurrent controller
`timescale 1ns/1ps
`default_nettype none
module port_power_overcurrent_ctl_tb;
  // Short tick keeps millisecond counts cheap
  localparam int TICK = 20;
  logic mclk_i, rst_i, gang, wr, s_o, s_oe, s_pu;
  logic [5:0] on, p_oe, p_pu, p_o, flag;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [6:0] fault, lvl;
  logic [7:0] regs[int];
  logic [15:0] al [4] = '{16'h30ea, 16'h30eb, 16'h30e1, 16'h30ec};
  logic [31:0] rnd;
  int failures, total_checks, p;
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  ppc_port_power #(.TICK_CYCLES(TICK)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .gang_mode_i(gang),
    .port_power_on_i(on), .cfg_addr_i(addr), .cfg_wr_i(wr), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .port_power_sense_pin_i(lvl[5:0]), .port_power_sense_pin_o(p_o),
    .port_power_sense_pin_oe_o(p_oe), .port_power_sense_pullup_o(p_pu),
    .shared_power_sense_pin_i(lvl[6]), .shared_power_sense_pin_o(s_o),
    .shared_power_sense_pin_oe_o(s_oe), .shared_power_sense_pullup_o(s_pu), .oc_flag_o(flag));
  ppc_switch_model sw_u (.clk_i(mclk_i), .oe_i({s_oe, p_oe}), .drv_i({s_o, p_o}),
    .pull_i({s_pu, p_pu}), .fault_i(fault), .pin_o(lvl));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic [5:0] exp);
    chk({2'b00, flag}, {2'b00, exp});
  endtask
  // Expected drive and pull-up worked out from mode and requests
  task automatic chk_pins;
    chk({1'b0, s_oe, p_oe}, {1'b0, !(gang && |on), gang ? 6'h3f : ~on});
    chk({1'b0, s_pu, p_pu}, {1'b0, gang && |on, gang ? 6'h00 : on});
  endtask
  // Register model keeps only mapped places, min width as a nibble
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    // Let an edge pass so a following write raises the strobe only once
    cyc(1);
    if (regs.exists(a)) regs[a] = (a == 16'h30ea) ? (d & 8'h0f) : d;
  endtask
  task automatic rd_all;
    for (int i = 0; i < 4; i++) begin
      addr = al[i];
      cyc(2);
      chk(rdata, regs.exists(al[i]) ? regs[al[i]] : 8'h00);
    end
  endtask
  task automatic do_reset;
    rst_i = 1'b1;
    cyc(12);
    rst_i = 1'b0;
    regs[16'h30ea] = 8'h05;
    regs[16'h30eb] = 8'h14;
    regs[16'h30e1] = 8'h0a;
  endtask
  task automatic low(input int ch, input int n);
    fault[ch] = 1'b1;
    cyc(n);
    fault[ch] = 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {gang, wr, on, addr, wdata, fault, failures, total_checks} = '0;
    rnd = 32'h6e75bc9b;
    do_reset;
    rd_all;
    chk_pins;
    wr_reg(16'h30ea, 8'hf3);
    wr_reg(16'h30eb, 8'h08);
    wr_reg(16'h30ec, 8'h55);
    rd_all;
    rnd = xs(rnd);
    p = rnd % 6;
    on = rnd[13:8] | (6'h01 << p);
    fault[p] = 1'b1;
    cyc(1);
    chk_pins;
    cyc(159);
    fault[p] = 1'b0;
    cyc(3 * TICK);
    chk_flag(6'h00);
    wr_reg(16'h30e1, 8'h02);
    low(p, 5 * TICK);
    cyc(4);
    chk_flag(6'h01 << p);
    cyc(2 * TICK);
    chk_flag(6'h01 << p);
    on[p] = 1'b0;
    cyc(3);
    chk_flag(6'h00);
    // Short low alone is a transient, a second one inside the window is not
    on[p] = 1'b1;
    cyc(3 * TICK);
    low(p, TICK);
    cyc(2 * TICK);
    chk_flag(6'h00);
    low(p, TICK / 2);
    cyc(4);
    chk_flag(6'h01 << p);
    on[p] = 1'b0;
    cyc(3);
    on[p] = 1'b1;
    cyc(3 * TICK);
    low(p, TICK);
    cyc(10 * TICK);
    low(p, TICK / 2);
    cyc(4);
    chk_flag(6'h00);
    on = 6'h00;
    cyc(3);
    // Ganged: individual pins are held low and must be ignored
    gang = 1'b1;
    on = rnd[21:16] | 6'h01;
    cyc(1);
    chk_pins;
    cyc(8 * TICK);
    chk_flag(6'h00);
    low(6, 5 * TICK);
    cyc(4);
    chk_flag(6'h3f);
    on = 6'h00;
    cyc(3);
    chk_flag(6'h00);
    gang = 1'b0;
    on[p] = 1'b1;
    cyc(3 * TICK);
    low(p, 5 * TICK);
    cyc(4);
    chk_flag(6'h01 << p);
    do_reset;
    chk_flag(6'h00);
    rd_all;
    end_of_test;
  end
  // Whole sequence needs under 2000 cycles
  initial begin
    #40us;
    failures++;
    end_of_test;
  end
endmodule
`default_nettype wire
